// File: shared/eps_pkg.sv
package eps_pkg;

   // register byte offsets on the bus
   localparam logic [7:0] REG_CTRL   = 8'h00;    // nv_operation_control
   localparam logic [7:0] REG_KEY    = 8'h04;    // nv_unlock_key, write only
   localparam logic [7:0] REG_ADDR   = 8'h08;    // nv_target_address
   localparam logic [7:0] REG_LATCH  = 8'h0C;    // write latch data word
   localparam logic [7:0] REG_STATUS = 8'h10;    // sticky event status
   localparam logic [7:0] REG_CLEAR  = 8'h14;    // write one to clear status
   localparam logic [7:0] REG_ENABLE = 8'h18;    // interrupt enable
   localparam logic [7:0] REG_DATA   = 8'h1C;    // eeprom word at target address

   // control register fields
   localparam int CTL_START   = 15;              // start / busy bit
   localparam int CTL_WREN    = 14;              // write enable
   localparam int CTL_ERR     = 13;              // operation failed flag
   localparam int CTL_NOERASE = 12;              // program_without_erase_bit
   localparam logic [15:0] CTL_WMASK  = 16'h70FF; // bits software may write directly
   localparam logic [15:0] CTL_RESET  = 16'h0000;
   localparam logic [5:0]  OP_BULK    = 6'h10;   // bulk erase operation type
   localparam logic [3:0]  OP_WORD_HI = 4'h1;    // 0001xx single-word operation
   localparam logic [1:0]  OP_ERASE_LO = 2'h0;   // 000100 erases the word

   // unlock key bytes
   localparam logic [7:0] KEY_FIRST  = 8'h55;
   localparam logic [7:0] KEY_SECOND = 8'hAA;

   // eeprom geometry and placement
   localparam int          EE_WORDS    = 256;
   localparam int          EE_WIDTH    = 16;
   localparam logic [23:0] EE_BASE     = 24'h7F_FE00;
   localparam logic [15:0] ERASED_WORD = 16'hFFFF;

   // status / interrupt bits
   localparam int IRQ_DONE = 0;                  // nv_done_interrupt_flag
   localparam int IRQ_ERR  = 1;                  // start refused
   localparam int IRQ_W    = 2;
   localparam logic [IRQ_W-1:0] IRQ_RESET = 2'h0;

   // timing
   localparam int CLK_PERIOD_NS = 50;            // 20 MHz
   localparam int OP_TIME_NS    = 4_000_000;     // program / erase cycle time
   localparam int OP_CYCLES_DEF = (OP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // unlock detector states
   typedef enum logic [1:0] {
      LK_IDLE      = 2'b00,
      LK_GOT_FIRST = 2'b01,
      LK_OPEN      = 2'b10
   } eps_lock_t;

   // operation kinds
   typedef enum logic [1:0] {
      OPK_NONE  = 2'b00,
      OPK_BULK  = 2'b01,
      OPK_ERASE = 2'b10,
      OPK_PROG  = 2'b11
   } eps_op_t;

endpackage

// File: core/eps_word_store.sv
`timescale 1ns/1ps
`default_nettype none
module eps_word_store #(
   parameter int WORDS = 256,
   parameter int WIDTH = 16
) (
   input  wire logic                     clk,
   input  wire logic                     resetn,
   input  wire logic                     go,
   input  wire eps_pkg::eps_op_t         kind,
   input  wire logic [$clog2(WORDS)-1:0] index,
   input  wire logic [WIDTH-1:0]         wdata,
   input  wire logic                     keep_old,
   input  wire logic [$clog2(WORDS)-1:0] rindex,
   output logic      [WIDTH-1:0]         rdata
);
   import eps_pkg::*;

   logic [WIDTH-1:0] mem [WORDS];                // cell array, erased at reset

   // one storage word per entry
   for (genvar i = 0; i < WORDS; i++) begin : g_word
      always_ff @(posedge clk or negedge resetn) begin
         if (!resetn) begin
            mem[i] <= ERASED_WORD;
         end else if (go) begin
            case (kind)
               OPK_BULK: begin
                  mem[i] <= ERASED_WORD;
               end
               OPK_ERASE: begin
                  if (index == i[$clog2(WORDS)-1:0]) mem[i] <= ERASED_WORD;
               end
               OPK_PROG: begin
                  if (index == i[$clog2(WORDS)-1:0]) begin
                     // no pre-erase: bits can only be cleared
                     mem[i] <= keep_old ? (mem[i] & wdata) : wdata;
                  end
               end
               default: begin
                  mem[i] <= mem[i];
               end
            endcase
         end
      end
   end

   // read port
   assign rdata = mem[rindex];
endmodule
`default_nettype wire

// File: core/eps_nv_sequencer.sv
// The register offsets and register access over AHB-Lite are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module eps_nv_sequencer #(
   parameter int OP_CYCLES = eps_pkg::OP_CYCLES_DEF,
   parameter int WORDS     = eps_pkg::EE_WORDS
) (
   input  wire logic        clk,
   input  wire logic        resetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   output logic             nv_irq
);
   import eps_pkg::*;

   localparam int CNT_W = $clog2(OP_CYCLES + 1);
   localparam int IDX_W = $clog2(WORDS);

   logic             acc;          // address phase taken
   logic             wr_pend;      // write data phase pending
   logic [7:0]       wr_addr;      // write offset
   logic             rd_pend;      // read wait state
   logic [7:0]       rd_addr;      // read offset
   logic             key_wr;       // key data phase
   logic             ctrl_wr;      // control data phase
   eps_lock_t        lock_q;       // unlock detector
   eps_lock_t        mid_lock;     // after key data
   eps_lock_t        next_lock;    // after address phase
   logic             win_hit;      // control write inside window
   logic             win_q;        // that write's data phase is allowed
   logic [15:0]      ctrl_q;       // nv_operation_control
   logic [23:0]      addr_q;       // nv_target_address
   logic [15:0]      latch_q;      // write latch
   eps_op_t          op_q;         // running operation
   eps_op_t          new_op;       // decoded from write data
   logic             new_valid;    // write data names a legal op
   logic             start_ok;     // cycle begins
   logic             start_bad;    // start refused
   logic             finish;       // cycle ends
   logic [CNT_W-1:0] cnt_q;        // cycle timer
   logic [IRQ_W-1:0] status_q;     // sticky events
   logic [IRQ_W-1:0] enable_q;     // interrupt mask
   logic [IRQ_W-1:0] next_status;
   logic [IRQ_W-1:0] next_enable;
   logic [15:0]      ee_rdata;     // eeprom read word
   logic             busy;

   assign acc     = hsel && hready && htrans[1];
   assign key_wr  = wr_pend && (wr_addr == REG_KEY);
   assign ctrl_wr = wr_pend && (wr_addr == REG_CTRL);
   assign busy    = ctrl_q[CTL_START];
   assign finish  = busy && (cnt_q == '0);

   // bus phase tracking; reads get one wait state so writes land first
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         wr_pend   <= 1'b0;
         wr_addr   <= 8'h00;
         rd_pend   <= 1'b0;
         rd_addr   <= 8'h00;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end else begin
         wr_pend <= acc && hwrite;
         rd_pend <= acc && !hwrite;
         if (acc) begin
            wr_addr <= haddr[7:0];
            rd_addr <= haddr[7:0];
         end
         hreadyout <= !(acc && !hwrite);
         hresp     <= 1'b0;
      end
   end

   // read data mux, taken in the wait state
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         hrdata <= 32'h0000_0000;
      end else if (rd_pend) begin
         case (rd_addr)
            REG_CTRL:   hrdata <= {16'h0000, ctrl_q};
            REG_KEY:    hrdata <= 32'h0000_0000;
            REG_ADDR:   hrdata <= {8'h00, addr_q};
            REG_LATCH:  hrdata <= {16'h0000, latch_q};
            REG_STATUS: hrdata <= {{(32-IRQ_W){1'b0}}, status_q};
            REG_ENABLE: hrdata <= {{(32-IRQ_W){1'b0}}, enable_q};
            REG_DATA:   hrdata <= {16'h0000, ee_rdata};
            default:    hrdata <= 32'h0000_0000;  // unmapped and clear read zero
         endcase
      end
   end

   // unlock detector: key data first, then the next address phase
   always_comb begin
      mid_lock = lock_q;
      if (key_wr) begin
         if (hwdata[7:0] == KEY_FIRST) begin
            mid_lock = LK_GOT_FIRST;
         end else if (hwdata[7:0] == KEY_SECOND && lock_q == LK_GOT_FIRST) begin
            mid_lock = LK_OPEN;
         end else begin
            mid_lock = LK_IDLE;
         end
      end
      next_lock = mid_lock;
      win_hit   = 1'b0;
      if (acc) begin
         // window lasts one transfer only
         win_hit = (mid_lock == LK_OPEN) && hwrite && (haddr[7:0] == REG_CTRL);
         if (mid_lock == LK_OPEN || !(hwrite && haddr[7:0] == REG_KEY)) begin
            next_lock = LK_IDLE;
         end
      end
   end

   // unlock state registers
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         lock_q <= LK_IDLE;
         win_q  <= 1'b0;
      end else begin
         lock_q <= next_lock;
         win_q  <= win_hit;
      end
   end

   // decode the operation type from the written control word
   always_comb begin
      new_op    = OPK_NONE;
      new_valid = 1'b0;
      if (hwdata[5:0] == OP_BULK) begin
         new_op    = OPK_BULK;
         new_valid = hwdata[CTL_WREN];
      end else if (hwdata[5:2] == OP_WORD_HI) begin
         new_op    = (hwdata[1:0] == OP_ERASE_LO) ? OPK_ERASE : OPK_PROG;
         new_valid = hwdata[CTL_WREN] && (addr_q[23:9] == EE_BASE[23:9]);
      end
   end

   assign start_ok  = ctrl_wr && win_q && !busy && hwdata[CTL_START] && new_valid;
   assign start_bad = ctrl_wr && win_q && !busy && hwdata[CTL_START] && !new_valid;

   // control register
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         ctrl_q <= CTL_RESET;
         op_q   <= OPK_NONE;
      end else begin
         if (ctrl_wr && !busy) begin
            // start bit only rises through the window
            ctrl_q <= (hwdata[15:0] & CTL_WMASK) | {start_ok, 15'h0000};
            if (start_ok) begin
               ctrl_q[CTL_ERR] <= 1'b0;
               op_q            <= new_op;
            end
            if (start_bad) ctrl_q[CTL_ERR] <= 1'b1;
         end else if (finish) begin
            ctrl_q[CTL_START] <= 1'b0;
         end
      end
   end

   // cycle timer
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         cnt_q <= '0;
      end else if (start_ok) begin
         cnt_q <= CNT_W'(OP_CYCLES - 1);
      end else if (busy && cnt_q != '0) begin
         cnt_q <= cnt_q - 1'b1;
      end
   end

   // target address and latch, frozen while a cycle runs
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         addr_q  <= EE_BASE;
         latch_q <= 16'h0000;
      end else if (wr_pend && !busy) begin
         if (wr_addr == REG_ADDR)  addr_q  <= hwdata[23:0];
         if (wr_addr == REG_LATCH) latch_q <= hwdata[15:0];
      end
   end

   // sticky status, mask and interrupt; a new event beats the clear
   always_comb begin
      next_status = status_q;
      next_enable = enable_q;
      if (wr_pend && wr_addr == REG_CLEAR)  next_status = status_q & ~hwdata[IRQ_W-1:0];
      if (wr_pend && wr_addr == REG_ENABLE) next_enable = hwdata[IRQ_W-1:0];
      next_status[IRQ_DONE] = next_status[IRQ_DONE] | finish;
      next_status[IRQ_ERR]  = next_status[IRQ_ERR] | start_bad;
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         status_q <= IRQ_RESET;
         enable_q <= IRQ_RESET;
         nv_irq   <= 1'b0;
      end else begin
         status_q <= next_status;
         enable_q <= next_enable;
         nv_irq   <= |(next_status & next_enable);
      end
   end

   // eeprom cell array
   eps_word_store #(
      .WORDS (WORDS),
      .WIDTH (EE_WIDTH)
   ) u_eps_word_store (
      .clk      (clk),
      .resetn   (resetn),
      .go       (finish),
      .kind     (op_q),
      .index    (addr_q[IDX_W:1]),
      .wdata    (latch_q),
      .keep_old (ctrl_q[CTL_NOERASE]),
      .rindex   (addr_q[IDX_W:1]),
      .rdata    (ee_rdata)
   );

   // checks
   chk_key_reads_zero: assert property (@(posedge clk) disable iff (!resetn)
      (rd_pend && rd_addr == REG_KEY) |=> (hrdata == 32'h0000_0000))
      else $error("key register read back nonzero");

   chk_unlock_order: assert property (@(posedge clk) disable iff (!resetn)
      $rose(lock_q == LK_OPEN) |-> ($past(lock_q) == LK_GOT_FIRST && $past(key_wr)))
      else $error("unlock opened without ordered key pair");

   chk_window_single: assert property (@(posedge clk) disable iff (!resetn)
      (lock_q == LK_OPEN && acc) |=> (lock_q != LK_OPEN))
      else $error("unlock window outlived one transfer");

   chk_start_begins: assert property (@(posedge clk) disable iff (!resetn)
      start_ok |=> (busy && cnt_q == CNT_W'(OP_CYCLES - 1)))
      else $error("valid start did not begin a cycle");

   chk_done_flags: assert property (@(posedge clk) disable iff (!resetn)
      finish |=> (!busy && status_q[IRQ_DONE]))
      else $error("completion did not clear start and set done");

   chk_start_held: assert property (@(posedge clk) disable iff (!resetn)
      (busy && cnt_q != '0) |=> busy)
      else $error("start bit dropped before cycle end");

   chk_busy_ignore: assert property (@(posedge clk) disable iff (!resetn)
      (busy && ctrl_wr && cnt_q != '0) |=> ($stable(ctrl_q) && $stable(op_q)))
      else $error("control changed during a running cycle");

   chk_locked_write: assert property (@(posedge clk) disable iff (!resetn)
      (ctrl_wr && !win_q && !busy) |=> !busy)
      else $error("start set outside the unlock window");

   chk_bulk_type: assert property (@(posedge clk) disable iff (!resetn)
      (start_ok && hwdata[15:0] == 16'hC050) |=> (op_q == OPK_BULK))
      else $error("bulk erase code not decoded");

   chk_irq_level: assert property (@(posedge clk) disable iff (!resetn)
      nv_irq == |(status_q & enable_q))
      else $error("interrupt output disagrees with status and mask");

   chk_read_wait: assert property (@(posedge clk) disable iff (!resetn)
      (acc && !hwrite) |=> (!hreadyout ##1 hreadyout))
      else $error("read wait state not exactly one cycle");

   chk_resp_okay: assert property (@(posedge clk) disable iff (!resetn)
      hresp == 1'b0)
      else $error("bus response not okay");

   chk_word_type: assert property (@(posedge clk) disable iff (!resetn)
      (start_ok && hwdata[5:2] == OP_WORD_HI) |=> (op_q == OPK_ERASE || op_q == OPK_PROG))
      else $error("single-word operation type not decoded");

   chk_word_erase: assert property (@(posedge clk) disable iff (!resetn)
      (start_ok && hwdata[15:0] == 16'hC004) |=> (op_q == OPK_ERASE))
      else $error("word erase code not decoded");

   chk_word_range: assert property (@(posedge clk) disable iff (!resetn)
      (busy && op_q != OPK_BULK) |-> (addr_q >= EE_BASE))
      else $error("word operation outside the eeprom range");
endmodule
`default_nettype wire

// File: dv/tb_eps_nv_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
module tb_eps_nv_sequencer;
   import eps_pkg::*;
   localparam int OPC = 24;          // shortened cycle, outlasts the busy-write checks
   logic        clk;
   logic        resetn;
   logic        hsel;
   logic [31:0] haddr;
   logic [1:0]  htrans;
   logic        hwrite;
   logic [2:0]  hsize;
   logic [31:0] hwdata;
   logic        hready;
   logic [31:0] hrdata;
   logic        hreadyout;
   logic        hresp;
   logic        nv_irq;
   logic [15:0] ee_m [EE_WORDS];     // expected eeprom contents
   logic [31:0] rd;                  // last read word
   logic [23:0] ta;                  // current target address
   logic [15:0] lv;                  // current latch value
   logic [15:0] ops [4];             // single-word control codes
   int          n_errors;
   int          checked;

   assign hready = hreadyout;        // the only slave

   eps_nv_sequencer #(.OP_CYCLES(OPC), .WORDS(EE_WORDS)) u_eps_nv_sequencer (
      .clk(clk), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .nv_irq(nv_irq));

   // free running 20 MHz clock
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   task automatic results();
      $display("errors %0d checks %0d", n_errors, checked);
      if (n_errors == 0 && checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task automatic chk_reg(input string nm, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e) begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic chk_bit(input string nm, input logic e, input logic g);
      checked++;
      if (g !== e) begin
         n_errors++;
         $display("wrong value %s expected %b seen %b", nm, e, g);
      end
   endtask

   // one single transfer, entered just after a rising edge; hready taken at rising edges
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
      hsel   <= 1'b1;
      haddr  <= {24'h00_0000, a};
      hwrite <= w;
      htrans <= 2'b10;
      @(posedge clk);
      while (hready !== 1'b1) @(posedge clk);
      htrans <= 2'b00;
      hwdata <= d;
      @(posedge clk);
      while (hready !== 1'b1) @(posedge clk);
      q = hrdata;
      chk_bit("hresp", 1'b0, hresp);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask

   task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string nm);
      bus(1'b0, a, 32'h0000_0000, rd);
      chk_reg(nm, e, rd);
   endtask

   task automatic chk_irq(input logic e);
      @(negedge clk);
      chk_bit("nv_irq", e, nv_irq);
      @(posedge clk);
   endtask

   task automatic unlock();
      wr(REG_KEY, 32'h0000_0055);
      wr(REG_KEY, 32'h0000_00AA);
   endtask

   // expected word after an operation
   function automatic logic [15:0] exp_word(input logic [15:0] old, input logic [15:0] c);
      if (c[5:0] == OP_BULK || c[1:0] == OP_ERASE_LO) return ERASED_WORD;
      if (c[CTL_NOERASE]) return old & lv;
      return lv;
   endfunction

   task automatic start_op(input logic [15:0] c);
      wr(REG_CTRL, {16'h0000, c & 16'h7FFF});
      unlock();
      wr(REG_CTRL, {16'h0000, c});
      rdc(REG_CTRL, {16'h0000, c}, "ctrl busy");
   endtask

   task automatic wait_op(input logic [15:0] c);
      int n;
      n = 0;
      while (rd[CTL_START] === 1'b1 && n < 4 * OPC) begin
         bus(1'b0, REG_CTRL, 32'h0000_0000, rd);
         n++;
      end
      chk_reg("ctrl done", {16'h0000, c & 16'h7FFF}, rd);
      if (c[5:0] == OP_BULK) begin
         foreach (ee_m[i]) ee_m[i] = ERASED_WORD;
      end else begin
         ee_m[ta[8:1]] = exp_word(ee_m[ta[8:1]], c);
      end
      rdc(REG_DATA, {16'h0000, ee_m[ta[8:1]]}, "eeprom word");
   endtask

   task automatic pick();
      ta = {EE_BASE[23:9], 8'($urandom), 1'b0};
      lv = 16'($urandom);
      wr(REG_ADDR, {8'h00, ta});
      wr(REG_LATCH, {16'h0000, lv});
   endtask

   // cut a hang short
   initial begin
      repeat (30000) @(posedge clk);
      n_errors++;
      results();
   end

   initial begin
      void'($urandom(48748));
      ops = '{16'hC005, 16'hD006, 16'hC004, 16'hD007};
      resetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0000_0000;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'b010;
      hwdata = 32'h0000_0000;
      n_errors = 0;
      checked = 0;
      rd = 32'h0000_0000;
      foreach (ee_m[i]) ee_m[i] = ERASED_WORD;
      repeat (6) @(posedge clk);
      resetn <= 1'b1;
      @(posedge clk);
      // reset values, write-only and unmapped places
      rdc(REG_CTRL, 32'h0000_0000, "ctrl reset");
      rdc(REG_ADDR, 32'h007F_FE00, "addr reset");
      rdc(REG_STATUS, 32'h0000_0000, "status reset");
      wr(REG_KEY, 32'h0000_0055);
      rdc(REG_KEY, 32'h0000_0000, "key readback");
      rdc(8'h20, 32'h0000_0000, "unmapped");
      wr(REG_ENABLE, 32'h0000_0001);
      // random single-word operations, every kind
      for (int k = 0; k < 8; k++) begin
         pick();
         start_op(ops[k % 4]);
         wait_op(ops[k % 4]);
         chk_irq(1'b1);
         wr(REG_CLEAR, 32'h0000_0001);
         chk_irq(1'b0);
      end
      // word erase with the literal code, then bulk erase elsewhere
      pick();
      start_op(16'hC005);
      wait_op(16'hC005);
      start_op(16'hC004);
      wait_op(16'hC004);
      pick();
      start_op(16'hC005);
      wait_op(16'hC005);
      wr(REG_ADDR, 32'h0000_0000);
      start_op(16'hC050);
      wait_op(16'hC050);
      wr(REG_ADDR, {8'h00, ta});
      rdc(REG_DATA, {16'h0000, ERASED_WORD}, "bulk erased");
      wr(REG_CLEAR, 32'h0000_0003);
      // broken unlock sequences leave start clear
      pick();
      for (int v = 0; v < 3; v++) begin
         wr(REG_CTRL, 32'h0000_4005);
         wr(REG_KEY, 32'h0000_0055);
         if (v == 0) wr(REG_KEY, {24'h00_0000, 8'($urandom_range(8'h54, 8'h00))});
         if (v == 1) rdc(REG_STATUS, 32'h0000_0000, "status idle");
         wr(REG_KEY, 32'h0000_00AA);
         if (v == 2) rdc(REG_STATUS, 32'h0000_0000, "status idle");
         wr(REG_CTRL, 32'h0000_C005);
         rdc(REG_CTRL, 32'h0000_4005, "ctrl no start");
      end
      rdc(REG_DATA, {16'h0000, ee_m[ta[8:1]]}, "word untouched");
      // illegal start raises the error flag
      unlock();
      wr(REG_CTRL, 32'h0000_C000);
      rdc(REG_CTRL, 32'h0000_6000, "ctrl error");
      rdc(REG_STATUS, 32'h0000_0002, "status refused");
      chk_irq(1'b0);
      wr(REG_ENABLE, 32'h0000_0003);
      chk_irq(1'b1);
      wr(REG_CLEAR, 32'h0000_0003);
      chk_irq(1'b0);
      // a second start and latch write while busy are ignored
      pick();
      start_op(16'hC005);
      unlock();
      wr(REG_CTRL, 32'h0000_C004);
      wr(REG_LATCH, {16'h0000, ~lv});
      rdc(REG_ADDR, {8'h00, ta}, "addr while busy");
      rdc(REG_CTRL, 32'h0000_C005, "ctrl while busy");
      wait_op(16'hC005);
      // masked completion sets status but not the line
      wr(REG_CLEAR, 32'h0000_0003);
      wr(REG_ENABLE, 32'h0000_0000);
      pick();
      start_op(16'hC004);
      wait_op(16'hC004);
      rdc(REG_STATUS, 32'h0000_0001, "status done");
      chk_irq(1'b0);
      results();
   end
endmodule
`default_nettype wire
